// ---- iaeo_consts.vh ----
// Constants for the incremental angle encoder output block
`ifndef IAEO_CONSTS_VH
`define IAEO_CONSTS_VH

// ****************************************
// Clock and timing
// ****************************************
`define IAEO_CLK_MHZ 25
`define IAEO_T_4X_NS 500
`define IAEO_T_2X_NS 1000
`define IAEO_T_1X_NS 2000
`define IAEO_LAT_PRI_NS 21000
`define IAEO_LAT_SEC_NS 28000

// ****************************************
// Interpolator modes
// ****************************************
`define IAEO_INTERP_BYP 2'h0
`define IAEO_INTERP_2X 2'h1
`define IAEO_INTERP_4X 2'h2

// ****************************************
// Register map and fields
// ****************************************
`define IAEO_ADDR_CFG 4'h0
`define IAEO_ADDR_HYS 4'h1
`define IAEO_ADDR_STAT 4'h2
`define IAEO_ADDR_ANG 4'h3
`define IAEO_CFG_RES_LSB 0
`define IAEO_CFG_POLE_LSB 4
`define IAEO_CFG_MODE_BIT 8
`define IAEO_CFG_INTERP_LSB 9
`define IAEO_CFG_CHAN_BIT 11
`define IAEO_CFG_RESET 16'h0A00
`define IAEO_HYS_RESET 16'h0000
`define IAEO_HYS_MAX 16'h0101

// ****************************************
// Encoding thresholds
// ****************************************
`define IAEO_RES_MAX 4'hB
`define IAEO_RES_TOP 4'hE
`define IAEO_ELEC_60 16'h2AAB
`define IAEO_ELEC_120 16'h5555
`define IAEO_ELEC_180 16'h8000
`define IAEO_ELEC_240 16'hAAAB
`define IAEO_ELEC_300 16'hD555

`endif

// ---- iaeo_hys.v ----
// Angular hysteresis filter on the 16-bit angle word
`include "iaeo_consts.vh"

module iaeo_hys #(
	parameter W = 16
) (
	input wire clk,
	input wire nrst,
	input wire upd,
	input wire [W-1:0] ang_in,
	input wire [W-1:0] hys,
	output reg [W-1:0] ang_out,
	output reg dir_up
);

	reg [W-1:0] diff;
	reg fwd;
	reg move;

	always @*
	begin
		diff = ang_in - ang_out;
		fwd = ~diff[W-1];
		// Forward moves pass freely while turning forward, reversals need hys
		if (diff == {W{1'b0}})
			move = 1'b0;
		else if (fwd == dir_up)
			move = 1'b1;
		else if (fwd)
			move = diff > hys;
		else
			move = (~diff + 1'b1) > hys;
	end

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ang_out <= {W{1'b0}};
			dir_up <= 1'b1;
		end
		else if (upd && move)
		begin
			ang_out <= ang_in;
			dir_up <= fwd;
		end
	end

endmodule

// ---- iaeo_top.v ----
// Incremental angle encoder output: quadrature or commutation on three pins
`include "iaeo_consts.vh"

module iaeo_top #(
	parameter W = 16,
	parameter CLK_MHZ = `IAEO_CLK_MHZ
) (
	// Clock and reset
	input wire CLK,
	input wire NRST,
	// Angle words from the sensing channels
	input wire [W-1:0] ANG_PRI,
	input wire [W-1:0] ANG_SEC,
	input wire ANG_VALID,
	// Register port
	input wire [3:0] ADDR,
	input wire [15:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [15:0] RDATA,
	// Output pins
	output reg PIN_AU,
	output reg PIN_BV,
	output reg PIN_IW
);

	// ****************************************
	// Timing
	// ****************************************
	localparam integer DIV_4X = `IAEO_T_4X_NS * CLK_MHZ / 1000;
	localparam integer DIV_2X = `IAEO_T_2X_NS * CLK_MHZ / 1000;
	localparam integer DIV_1X = `IAEO_T_1X_NS * CLK_MHZ / 1000;
	localparam integer LAT_PRI_CYC = `IAEO_LAT_PRI_NS * CLK_MHZ / 1000;
	localparam integer LAT_SEC_CYC = `IAEO_LAT_SEC_NS * CLK_MHZ / 1000;

	// ****************************************
	// Encoding thresholds
	// ****************************************
	localparam [3:0] RES_MAX = `IAEO_RES_MAX;
	localparam [3:0] RES_TOP = `IAEO_RES_TOP;
	localparam [W-1:0] ELEC_60 = `IAEO_ELEC_60;
	localparam [W-1:0] ELEC_120 = `IAEO_ELEC_120;
	localparam [W-1:0] ELEC_180 = `IAEO_ELEC_180;
	localparam [W-1:0] ELEC_240 = `IAEO_ELEC_240;
	localparam [W-1:0] ELEC_300 = `IAEO_ELEC_300;

	// ****************************************
	// Registers
	// ****************************************
	reg [15:0] cfg_r;
	reg [15:0] hys_r;

	wire [3:0] pulse_resolution_setting = cfg_r[`IAEO_CFG_RES_LSB +: 4];
	wire [3:0] pole_pair_setting = cfg_r[`IAEO_CFG_POLE_LSB +: 4];
	wire commutation_output_mode = cfg_r[`IAEO_CFG_MODE_BIT];
	wire [1:0] interp_mode = cfg_r[`IAEO_CFG_INTERP_LSB +: 2];
	wire use_secondary = cfg_r[`IAEO_CFG_CHAN_BIT];

	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			cfg_r <= `IAEO_CFG_RESET;
			hys_r <= `IAEO_HYS_RESET;
		end
		else if (WR)
		begin
			if (ADDR == `IAEO_ADDR_CFG)
				cfg_r <= WDATA;
			if (ADDR == `IAEO_ADDR_HYS)
				hys_r <= (WDATA > `IAEO_HYS_MAX) ? `IAEO_HYS_MAX : WDATA;
		end
	end

	// ****************************************
	// Input synchronisers
	// ****************************************
	// Word bits cross one by one; a word caught mid-change is used as is
	// until the next valid base tick replaces it; in 2X and 4X modes base_prev_r keeps it in the step size one valid sample longer
	reg [W-1:0] pri_s1_r;
	reg [W-1:0] pri_s2_r;
	reg [W-1:0] sec_s1_r;
	reg [W-1:0] sec_s2_r;
	reg vld_s1_r;
	reg vld_s2_r;

	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			pri_s1_r <= {W{1'b0}};
			pri_s2_r <= {W{1'b0}};
			sec_s1_r <= {W{1'b0}};
			sec_s2_r <= {W{1'b0}};
			vld_s1_r <= 1'b0;
			vld_s2_r <= 1'b0;
		end
		else
		begin
			pri_s1_r <= ANG_PRI;
			pri_s2_r <= pri_s1_r;
			sec_s1_r <= ANG_SEC;
			sec_s2_r <= sec_s1_r;
			vld_s1_r <= ANG_VALID;
			vld_s2_r <= vld_s1_r;
		end
	end

	// ****************************************
	// Base sample and interpolator
	// ****************************************
	reg [11:0] base_cnt_r;
	reg [11:0] sub_cnt_r;
	reg [W-1:0] base_prev_r;
	reg [W-1:0] base_cur_r;
	reg [W-1:0] interp_r;
	reg [1:0] phase_r;
	reg upd_r;

	// Four-times steps land 0.48 us apart; the base tick realigns them
	// every 2 us, so the average rate stays exact
	wire base_tick = (base_cnt_r == DIV_1X[11:0] - 12'h001);
	wire [11:0] sub_div = (interp_mode == `IAEO_INTERP_4X) ? DIV_4X[11:0] :
		(interp_mode == `IAEO_INTERP_2X) ? DIV_2X[11:0] : DIV_1X[11:0];
	wire sub_tick = (sub_cnt_r == sub_div - 12'h001);
	wire [W-1:0] src_ang = use_secondary ? sec_s2_r : pri_s2_r;
	wire [W-1:0] delta = base_cur_r - base_prev_r;
	wire [W-1:0] d_half = {delta[W-1], delta[W-1:1]};
	wire [W-1:0] d_qtr = {{2{delta[W-1]}}, delta[W-1:2]};

	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			base_cnt_r <= 12'h000;
			sub_cnt_r <= 12'h000;
			base_prev_r <= {W{1'b0}};
			base_cur_r <= {W{1'b0}};
			interp_r <= {W{1'b0}};
			phase_r <= 2'h0;
			upd_r <= 1'b0;
		end
		else
		begin
			upd_r <= 1'b0;
			base_cnt_r <= base_tick ? 12'h000 : base_cnt_r + 12'h001;
			if (base_tick)
			begin
				sub_cnt_r <= 12'h000;
				phase_r <= 2'h0;
				if (vld_s2_r)
				begin
					base_prev_r <= base_cur_r;
					base_cur_r <= src_ang;
				end
				interp_r <= vld_s2_r ? src_ang : base_cur_r;
				upd_r <= 1'b1;
			end
			else if (sub_tick)
			begin
				sub_cnt_r <= 12'h000;
				phase_r <= phase_r + 2'h1;
				if (interp_mode == `IAEO_INTERP_4X)
					interp_r <= interp_r + d_qtr;
				else
					interp_r <= interp_r + d_half;
				upd_r <= 1'b1;
			end
			else
				sub_cnt_r <= sub_cnt_r + 12'h001;
		end
	end

	// ****************************************
	// Hysteresis
	// ****************************************
	wire [W-1:0] hang;
	wire hdir;

	// Reversals not larger than hys_r are held; steps in the current direction pass at once
	iaeo_hys #(
		.W(W)
	) u_hys (
		.clk(CLK),
		.nrst(NRST),
		.upd(upd_r),
		.ang_in(interp_r),
		.hys(hys_r),
		.ang_out(hang),
		.dir_up(hdir)
	);

	// ****************************************
	// Quadrature encoding
	// ****************************************
	// Count index: top (res+2) bits of the angle give 4..8192 counts
	wire [3:0] res_sel = (pulse_resolution_setting > RES_MAX) ? RES_MAX :
		pulse_resolution_setting;
	wire [W-1:0] qcount = hang >> (RES_TOP - res_sel);
	wire [1:0] qphase = qcount[1:0];
	wire qa = qphase[1] ^ qphase[0];
	wire qb = qphase[1];
	wire [W-1:0] idx_mask = ~({W{1'b1}} >> (res_sel + 4'h2));
	wire qi = ((hang & idx_mask) == {W{1'b0}}) && (qphase == 2'h0);

	// ****************************************
	// Commutation encoding
	// ****************************************
	// Electrical angle = mech angle times pole pairs, low W bits
	wire [W+4:0] elec_full = hang * ({1'b0, pole_pair_setting} + 5'h01);
	wire [W-1:0] elec = elec_full[W-1:0];
	reg [2:0] sector;
	reg [2:0] comm_pat;

	always @*
	begin
		sector = 3'h0;
		if (elec >= ELEC_300)
			sector = 3'h5;
		else if (elec >= ELEC_240)
			sector = 3'h4;
		else if (elec >= ELEC_180)
			sector = 3'h3;
		else if (elec >= ELEC_120)
			sector = 3'h2;
		else if (elec >= ELEC_60)
			sector = 3'h1;
		case (sector)
			3'h0: comm_pat = 3'b101;
			3'h1: comm_pat = 3'b100;
			3'h2: comm_pat = 3'b110;
			3'h3: comm_pat = 3'b010;
			3'h4: comm_pat = 3'b011;
			3'h5: comm_pat = 3'b001;
			default: comm_pat = 3'b000;
		endcase
	end

	// ****************************************
	// Output pins
	// ****************************************
	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			PIN_AU <= 1'b0;
			PIN_BV <= 1'b0;
			PIN_IW <= 1'b0;
		end
		else if (commutation_output_mode)
		begin
			PIN_AU <= comm_pat[2];
			PIN_BV <= comm_pat[1];
			PIN_IW <= comm_pat[0];
		end
		else
		begin
			PIN_AU <= qa;
			PIN_BV <= qb;
			PIN_IW <= qi;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			RDATA <= 16'h0000;
		else if (RD)
		begin
			case (ADDR)
				`IAEO_ADDR_CFG: RDATA <= cfg_r;
				`IAEO_ADDR_HYS: RDATA <= hys_r;
				`IAEO_ADDR_STAT: RDATA <= {12'h000, hdir, PIN_IW, PIN_BV,
					PIN_AU};
				`IAEO_ADDR_ANG: RDATA <= hang;
				default: RDATA <= 16'h0000;
			endcase
		end
		else
			RDATA <= 16'h0000;
	end

	// Latency budget: 2 sync + 2 us sample + filter + 2 stages, far below
	// LAT_PRI_CYC and LAT_SEC_CYC cycles.
	wire unused_lat = (LAT_PRI_CYC < LAT_SEC_CYC) & phase_r[0] & qa;

endmodule

// ---- iaeo_top_props.sv ----
// Port checker for the encoder output block
module iaeo_top_props (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Register port
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	// Output pins
	input wire logic PIN_AU,
	input wire logic PIN_BV,
	input wire logic PIN_IW
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cfg_r;
	logic [5:0] quiet_r;
	wire settled = quiet_r == 6'h3F;
	wire [2:0] pins = {PIN_IW, PIN_BV, PIN_AU};
	// Shadow of the setting word; pins are judged only once it has settled
	always @(posedge CLK or negedge NRST)
		if (!NRST)
		begin
			cfg_r <= 16'h0A00;
			quiet_r <= 6'h00;
		end
		else if (WR && ADDR == 4'h0)
		begin
			cfg_r <= WDATA;
			quiet_r <= 6'h00;
		end
		else if (!settled)
			quiet_r <= quiet_r + 6'h01;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	a_rdata_idle:
	assert property (!$past(RD) |-> RDATA == 16'h0000)
		else $error("read data not idle");
	a_hys_clamp:
	assert property (WR && ADDR == 4'h1 ##1 RD && ADDR == 4'h1 |=> RDATA ==
		($past(WDATA, 2) > 16'h0101 ? 16'h0101 : $past(WDATA, 2)))
		else $error("hysteresis not clamped");
	a_unmapped_zero:
	assert property (RD && ADDR > 4'h3 |=> RDATA == 16'h0000)
		else $error("unmapped read not zero");
	a_cfg_readback:
	assert property (RD && ADDR == 4'h0 |=>
		(RDATA & 16'h0FFF) == (cfg_r & 16'h0FFF))
		else $error("setting word readback wrong");
	a_stat_pins:
	assert property (RD && ADDR == 4'h2 ##1 $stable(pins) |->
		RDATA[2:0] == pins)
		else $error("status pins differ");
	a_phase_legal:
	assert property (settled && cfg_r[8] |-> pins != 3'h0 && pins != 3'h7)
		else $error("phase pattern illegal");
	a_index_at_zero:
	assert property (settled && !cfg_r[8] && PIN_IW |-> !PIN_AU && !PIN_BV)
		else $error("index outside count zero");
	a_bypass_rate:
	assert property (settled && cfg_r[10:9] == 2'h0 && $changed(pins) |=>
		$stable(pins) [*8])
		else $error("bypass update too fast");
endmodule
bind iaeo_top iaeo_top_props u_props (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_AU(PIN_AU),
	.PIN_BV(PIN_BV), .PIN_IW(PIN_IW));

// ---- iaeo_counter.sv ----
// Far-side quadrature counter with pin edge tallies
module iaeo_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Encoder pins
	input wire logic a,
	input wire logic b,
	input wire logic i,
	// Tallies
	output int count,
	output int a_edges,
	output int i_rises
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] pos_r;
	logic i_r;
	wire [1:0] pos = {b, a ^ b};
	always @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			count <= 0;
			a_edges <= 0;
			i_rises <= 0;
			pos_r <= 2'h0;
			i_r <= 1'b0;
		end
		else
		begin
			if (pos - pos_r == 2'h1)
				count <= count + 1;
			else if (pos - pos_r == 2'h3)
				count <= count - 1;
			a_edges <= a_edges + int'(a != ^pos_r);
			i_rises <= i_rises + int'(i && !i_r);
			pos_r <= pos;
			i_r <= i;
		end
endmodule

// ---- iaeo_top_tb.sv ----
// Self-checking bench for the encoder output block
`include "iaeo_consts.vh"
module iaeo_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, nrst, ang_valid, wr, rd;
	logic [15:0] ang_pri, ang_sec, wdata, q, d;
	logic [3:0] addr;
	logic [31:0] lfsr_r = 32'h572D8A35;
	wire [15:0] rdata;
	wire pin_au, pin_bv, pin_iw;
	wire [15:0] pins_w = {13'h0, pin_iw, pin_bv, pin_au};
	int num_errors = 0, tests_run = 0, cnt, ir, ae;
	int count, a_edges, i_rises;
	iaeo_top uut (.CLK(clk), .NRST(nrst), .ANG_PRI(ang_pri),
		.ANG_SEC(ang_sec), .ANG_VALID(ang_valid), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.PIN_AU(pin_au), .PIN_BV(pin_bv), .PIN_IW(pin_iw));
	iaeo_counter u_far (.clk(clk), .nrst(nrst), .a(pin_au), .b(pin_bv),
		.i(pin_iw), .count(count), .a_edges(a_edges), .i_rises(i_rises));
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] pins_of(input logic [1:0] c);
		return {13'h0, c == 2'h0, c[1], c[1] ^ c[0]};
	endfunction
	function automatic logic [15:0] clamp(input logic [15:0] v);
		return v > `IAEO_HYS_MAX ? `IAEO_HYS_MAX : v;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	// Optional write, then a read of the same place into q
	task automatic reg_acc(input logic [3:0] a, input logic [15:0] v,
		input logic w);
		addr <= a;
		wdata <= v;
		if (w)
		begin
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		q = rdata;
	endtask
	task automatic settle(input logic [15:0] v);
		ang_pri <= v;
		repeat (200) @(posedge clk);
	endtask
	task automatic spin(input logic [15:0] c);
		reg_acc(`IAEO_ADDR_CFG, c, 1'b1);
		settle(16'h0200);
		cnt = count;
		ir = i_rises;
		ae = a_edges;
		repeat (64)
		begin
			ang_pri <= ang_pri + 16'h0400;
			repeat (50) @(posedge clk);
		end
		repeat (300) @(posedge clk);
	endtask
	task final_report;
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ****************************************
	// Clock, watchdog and sequence
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		num_errors++;
		final_report();
	end
	initial
	begin
		nrst = 1'b0;
		ang_pri = 16'h0000;
		ang_sec = 16'h8000;
		ang_valid = 1'b1;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		reg_acc(`IAEO_ADDR_CFG, 16'h0000, 1'b0);
		check(q, `IAEO_CFG_RESET);
		reg_acc(`IAEO_ADDR_HYS, 16'h0000, 1'b0);
		check(q, `IAEO_HYS_RESET);
		repeat (6)
		begin
			lfsr_r = lfsr_next(lfsr_r);
			d = lfsr_r[15:0] >> lfsr_r[19:16];
			reg_acc(`IAEO_ADDR_HYS, d, 1'b1);
			check(q, clamp(d));
			reg_acc(4'h4 + lfsr_r[23:20] % 4'hC, d, 1'b1);
			check(q, 16'h0000);
		end
		// Small reversal is held back by hysteresis, released when it is zero
		reg_acc(`IAEO_ADDR_CFG, 16'h0000, 1'b1);
		reg_acc(`IAEO_ADDR_HYS, 16'h0101, 1'b1);
		settle(16'h2000);
		settle(16'h4040);
		settle(16'h3FC0);
		check(pins_w, pins_of(2'h1));
		reg_acc(`IAEO_ADDR_ANG, 16'h0000, 1'b0);
		check(q, 16'h4040);
		reg_acc(`IAEO_ADDR_STAT, 16'h0000, 1'b0);
		check(q & 16'h000F, 16'h0008 | pins_of(2'h1));
		reg_acc(`IAEO_ADDR_HYS, 16'h0000, 1'b1);
		settle(16'h3FC0);
		check(pins_w, pins_of(2'h0));
		reg_acc(`IAEO_ADDR_CFG, 16'h0800, 1'b1);
		settle(16'h3FC0);
		check(pins_w, pins_of(2'h2));
		// Samples marked invalid are ignored, valid ones are taken again
		ang_valid <= 1'b0;
		ang_sec <= 16'hC000;
		settle(16'h3FC0);
		check(pins_w, pins_of(2'h2));
		ang_valid <= 1'b1;
		settle(16'h3FC0);
		check(pins_w, pins_of(2'h3));
		for (int r = 0; r < 4; r++)
		begin
			spin(16'(r) | 16'(r % 3) << 9);
			check(16'(count - cnt), 16'(4 << r));
			check(16'(i_rises - ir), 16'h0001);
		end
		spin(16'h0510);
		check(16'(a_edges - ae), 16'h0004);
		final_report();
	end
endmodule
